/* hw/idcmd_regs.svh */
// constants for the identify words and idle/geometry command logic
// Function
// R1: word 90 reports enhanced erase time code
// R2: word 91 low byte holds power level
// R3: bit 8 flags maximum security level
// R4: bit 5 flags enhanced erase support
// R5: expired flag aborts unlock/erase until reset
// R6: bits 3..0 frozen, locked, enabled, supported
// R7: bit 15 valid description, bit 14 zero
// R8: bits 13/12 level1 absent or disabled
// R9: low twelve bits give maximum current mA
// R10: bit 0 key scheme, others reserved
// R11: word 163 PIO max and selected codes
// R12: word 163 DMA max and selected codes
// R13: word 164 bits 2-0 io cycle
// R14: word 164 bits 5-3 memory cycle
// R15: word 164 bits 8-6 io udma max
// R16: word 164 bits 11-9 memory udma max
// R17: word 164 bits 14-12 selected udma
// R18: bit 15 validates card udma fields
// R19: idle commands: busy, idle, unbusy, interrupt
// R20: idle count times 5 ms sets powerdown
// R21: opcode 91h loads sectors and heads
// R22: host writes bit 6 zero, max head
// R23: reserved identify bits read zero
`ifndef IDCMD_REGS_SVH
`define IDCMD_REGS_SVH
`define OP_IDLE_A       8'h97
`define OP_IDLE_B       8'hE3
`define OP_IDLE_IMM_A   8'h95
`define OP_IDLE_IMM_B   8'hE1
`define OP_INIT_PARAMS  8'h91
`define OP_SEC_UNLOCK   8'hF2
`define OP_SEC_ERASE    8'hF4
`define WORD_ERASE_TIME 8'h5A
`define WORD_APM_LEVEL  8'h5B
`define WORD_SEC_STATUS 8'h80
`define WORD_POWER_REQ  8'hA0
`define WORD_KEY_MGMT   8'hA2
`define WORD_IDE_TIMING 8'hA3
`define WORD_CARD_TIMING 8'hA4
`define IDLE_TICK_NS    5000000
`define CLK_PERIOD_NS   100
`define IDLE_TICK_CYC   (`IDLE_TICK_NS / `CLK_PERIOD_NS)
`define DEF_SPT         8'h3F
`define DEF_HEADS       4'hF
`endif

/* hw/idcmd_pkg.sv */
// types shared by the identify and command logic
`default_nettype none
package idcmd_pkg;
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] sec_count;
        logic [7:0] drive_head;
    } taskfile_s;
    typedef struct packed {
        logic [7:0] erase_time;
        logic [7:0] apm_level;
        logic       sec_max_level;
        logic       enh_erase_sup;
        logic       sec_frozen;
        logic       sec_locked;
        logic       sec_enabled;
        logic       sec_supported;
        logic       power_desc_valid;
        logic       no_level1_commands;
        logic       level1_commands_disabled;
        logic [11:0] max_current_ma;
        logic       key_scheme_sup;
        logic [2:0] pio_max;
        logic [2:0] dma_max;
        logic [2:0] pio_sel;
        logic [2:0] dma_sel;
        logic [2:0] io_cycle;
        logic [2:0] mem_cycle;
        logic [2:0] io_udma_max;
        logic [2:0] mem_udma_max;
        logic [2:0] udma_sel;
        logic       card_udma_valid;
    } ident_cfg_s;
    typedef enum logic [3:0] {
        ST_READY = 4'h1,
        ST_BUSY  = 4'h2,
        ST_DONE  = 4'h4,
        ST_ABORT = 4'h8
    } cmd_state_e;
endpackage
`default_nettype wire

/* hw/ident_words.sv */
// identify word mux for the power, security and timing words
`default_nettype none
`include "idcmd_regs.svh"
module ident_words
(
    input  wire logic [7:0]          word_idx,
    input  wire idcmd_pkg::ident_cfg_s cfg,
    input  wire logic                sec_expired,
    output logic [15:0]              word_data
);
    import idcmd_pkg::*;

    // reserved values in 3-bit codes are clipped to zero
    function automatic logic [2:0] clip(input logic [2:0] v, input logic [2:0] lim);
        clip = (v > lim) ? 3'h0 : v;
    endfunction

    // unlisted words and reserved bits read zero (see R23)
    always_comb
    begin
        word_data = 16'h0000;
        case (word_idx)
            `WORD_ERASE_TIME: word_data = {8'h00, cfg.erase_time}; // see R1
            `WORD_APM_LEVEL:  word_data = {8'h00, cfg.apm_level}; // see R2
            `WORD_SEC_STATUS: word_data = {7'h00, cfg.sec_max_level & cfg.sec_enabled,
                                2'b00, cfg.enh_erase_sup, sec_expired, // see R3 see R4 see R5
                                cfg.sec_frozen, cfg.sec_locked, cfg.sec_enabled,
                                cfg.sec_supported}; // see R6
            `WORD_POWER_REQ:  word_data = {cfg.power_desc_valid, 1'b0, // see R7
                                cfg.no_level1_commands, cfg.level1_commands_disabled, // see R8
                                cfg.max_current_ma}; // see R9
            `WORD_KEY_MGMT:   word_data = {15'h0000, cfg.key_scheme_sup}; // see R10
            `WORD_IDE_TIMING: word_data = {4'h0, clip(cfg.dma_sel, 3'h2), // see R12
                                clip(cfg.pio_sel, 3'h2), clip(cfg.dma_max, 3'h2),
                                clip(cfg.pio_max, 3'h2)}; // see R11
            `WORD_CARD_TIMING: word_data = {cfg.card_udma_valid, // see R18
                                clip(cfg.udma_sel, 3'h6), // see R17
                                cfg.card_udma_valid ? clip(cfg.mem_udma_max, 3'h6) : 3'h0,
                                cfg.card_udma_valid ? clip(cfg.io_udma_max, 3'h6) : 3'h0,
                                clip(cfg.mem_cycle, 3'h3), // see R14 see R15 see R16
                                clip(cfg.io_cycle, 3'h3)}; // see R13
            default:          word_data = 16'h0000;
        endcase
    end
endmodule
`default_nettype wire

/* hw/idle_timer.sv */
// automatic power-down timer counting 5 ms ticks
`default_nettype none
`include "idcmd_regs.svh"
module idle_timer
#(
    parameter int TICK_CYC = `IDLE_TICK_CYC
)
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       load,
    input  wire logic [7:0] count,
    input  wire logic       activity,
    output logic            powerdown
);
    logic [7:0]  reload_r;
    logic [7:0]  ticks_r;
    logic [31:0] div_r;
    logic        tick;

    assign tick = (div_r == TICK_CYC - 1);

    // prescaler gives one pulse per 5 ms
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            div_r <= 32'h00000000;
        else if (load || activity || tick)
            div_r <= 32'h00000000;
        else
            div_r <= div_r + 32'h00000001;
    end

    // zero count disables power-down (see R20)
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            reload_r  <= 8'h00;
            ticks_r   <= 8'h00;
            powerdown <= 1'b0;
        end
        else if (load)
        begin
            reload_r  <= count;
            ticks_r   <= count;
            powerdown <= 1'b0;
        end
        else if (activity)
        begin
            ticks_r   <= reload_r;
            powerdown <= 1'b0;
        end
        else if (tick && reload_r != 8'h00 && !powerdown)
        begin
            if (ticks_r <= 8'h01)
                powerdown <= 1'b1; // see R20
            else
                ticks_r <= ticks_r - 8'h01;
        end
    end

    powerdown_clear_a: assert property (@(posedge core_clk) disable iff (rst) // see R20
        load && count == 8'h00 |=> !powerdown [*8])
        else $error("powerdown with zero count");
endmodule
`default_nettype wire

/* hw/ata_identify_power_cmds.sv */
// command executor for idle, idle immediate and geometry, plus identify words
`default_nettype none
`include "idcmd_regs.svh"
module ata_identify_power_cmds
#(
    parameter int TICK_CYC = `IDLE_TICK_CYC
)
(
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  cmd_valid,
    input  wire idcmd_pkg::taskfile_s  cmd_tf,
    input  wire idcmd_pkg::ident_cfg_s cfg,
    input  wire logic                  sec_count_exhausted,
    input  wire logic                  host_activity,
    input  wire logic [7:0]            word_idx,
    output logic [15:0]                word_data,
    output logic                       busy_status_bit,
    output logic                       cmd_abort,
    output logic                       cmd_irq,
    output logic                       idle_mode,
    output logic                       powerdown,
    output logic                       sec_expired,
    output logic [7:0]                 sectors_per_track,
    output logic [3:0]                 head_max
);
    import idcmd_pkg::*;

    cmd_state_e state_r;
    cmd_state_e state_nxt;
    logic       is_idle;
    logic       is_idle_imm;
    logic       is_geom;
    logic       is_sec_blocked;
    logic       timer_load;
    logic [7:0] count_r;
    logic       is_idle_r;
    logic       go_idle_r;

    // decode an opcode against its two aliases
    function automatic logic op_is(input logic [7:0] op, input logic [7:0] a,
                                   input logic [7:0] b);
        op_is = (op == a) || (op == b);
    endfunction

    assign is_idle        = op_is(cmd_tf.opcode, `OP_IDLE_A, `OP_IDLE_B);
    assign is_idle_imm    = op_is(cmd_tf.opcode, `OP_IDLE_IMM_A, `OP_IDLE_IMM_B);
    assign is_geom        = op_is(cmd_tf.opcode, `OP_INIT_PARAMS, `OP_INIT_PARAMS);
    assign is_sec_blocked = sec_expired && op_is(cmd_tf.opcode, `OP_SEC_UNLOCK, `OP_SEC_ERASE);
    assign timer_load     = (state_r == ST_BUSY) && is_idle_r;

    // expire flag only ends on reset; reset wins while it stands (see R5)
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            sec_expired <= 1'b0;
        else if (sec_count_exhausted)
            sec_expired <= 1'b1; // see R5
    end

    // command sequence: busy, act, unbusy with interrupt (see R19)
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_READY:
            begin
                if (cmd_valid && is_sec_blocked)
                    state_nxt = ST_ABORT; // see R5
                else if (cmd_valid && (is_idle || is_idle_imm || is_geom))
                    state_nxt = ST_BUSY;
            end
            ST_BUSY:  state_nxt = ST_DONE;
            ST_DONE:  state_nxt = ST_READY;
            ST_ABORT: state_nxt = ST_READY;
            default:  state_nxt = ST_READY;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state_r <= ST_READY;
        else
            state_r <= state_nxt;
    end

    // latch the command kind and count at acceptance
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            is_idle_r <= 1'b0;
            go_idle_r <= 1'b0;
            count_r   <= 8'h00;
        end
        else if (state_r == ST_READY && cmd_valid)
        begin
            is_idle_r <= is_idle;
            go_idle_r <= is_idle || is_idle_imm;
            count_r   <= cmd_tf.sec_count;
        end
    end

    // geometry load; only count and head fields used (see R21)
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sectors_per_track <= `DEF_SPT;
            head_max          <= `DEF_HEADS;
        end
        else if (state_r == ST_READY && cmd_valid && is_geom && !is_sec_blocked)
        begin
            sectors_per_track <= cmd_tf.sec_count; // see R21
            head_max          <= cmd_tf.drive_head[3:0]; // see R21
        end
    end

    // idle mode entered on the edge that ends busy, together with the interrupt
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            idle_mode <= 1'b0;
        else if (state_r == ST_BUSY && go_idle_r)
            idle_mode <= 1'b1; // see R19
        else if (host_activity)
            idle_mode <= 1'b0;
    end

    // status outputs are registered so busy drops with the interrupt pulse
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            busy_status_bit <= 1'b0;
            cmd_irq         <= 1'b0;
            cmd_abort       <= 1'b0;
        end
        else
        begin
            busy_status_bit <= (state_nxt == ST_BUSY);
            cmd_irq         <= (state_nxt == ST_DONE) || (state_nxt == ST_ABORT); // see R19
            cmd_abort       <= (state_nxt == ST_ABORT); // see R5
        end
    end

    idle_timer #(
        .TICK_CYC (TICK_CYC)
    ) u_timer (
        .core_clk  (core_clk),
        .rst       (rst),
        .load      (timer_load),
        .count     (count_r),
        .activity  (host_activity),
        .powerdown (powerdown)
    );

    ident_words u_words (
        .word_idx    (word_idx),
        .cfg         (cfg),
        .sec_expired (sec_expired),
        .word_data   (word_data)
    );

    // accepted idle: busy, then unbusy with interrupt and idle mode
    idle_sequence_a: assert property (@(posedge core_clk) disable iff (rst) // see R19
        state_r == ST_READY && cmd_valid && (is_idle || is_idle_imm) && !is_sec_blocked
        |=> busy_status_bit ##1 !busy_status_bit && cmd_irq && idle_mode)
        else $error("idle sequence wrong");

    // busy stands for exactly one cycle
    busy_pulse_a: assert property (@(posedge core_clk) disable iff (rst) // see R19
        busy_status_bit |=> !busy_status_bit)
        else $error("busy held too long");

    // interrupt is a single pulse, never beside busy
    irq_pulse_a: assert property (@(posedge core_clk) disable iff (rst) // see R19
        cmd_irq |-> !busy_status_bit ##1 !cmd_irq)
        else $error("interrupt pulse wrong");

    // commands offered while not ready are refused
    refuse_busy_a: assert property (@(posedge core_clk) disable iff (rst) // see R19
        state_r != ST_READY |=> !busy_status_bit)
        else $error("command taken while busy");

    // blocked security commands answer at once, never busy
    expired_abort_a: assert property (@(posedge core_clk) disable iff (rst) // see R5
        state_r == ST_READY && cmd_valid && is_sec_blocked |=> cmd_abort && !busy_status_bit)
        else $error("blocked command not aborted");

    // an abort always comes with the interrupt
    abort_irq_a: assert property (@(posedge core_clk) disable iff (rst) // see R5
        cmd_abort |-> cmd_irq && !busy_status_bit)
        else $error("abort without interrupt");

    // only reset ends the expired state
    expired_sticky_a: assert property (@(posedge core_clk) disable iff (rst) // see R5
        sec_expired |=> sec_expired)
        else $error("expire flag cleared");

    // status word mirrors the expired flag
    expire_bit_a: assert property (@(posedge core_clk) disable iff (rst) // see R5
        word_idx == `WORD_SEC_STATUS |-> word_data[4] == sec_expired)
        else $error("expire bit mismatch");

    // geometry takes sector count and head field one cycle after take
    geometry_load_a: assert property (@(posedge core_clk) disable iff (rst) // see R21
        state_r == ST_READY && cmd_valid && is_geom && !is_sec_blocked
        |=> sectors_per_track == $past(cmd_tf.sec_count)
            && head_max == $past(cmd_tf.drive_head[3:0]))
        else $error("geometry not loaded");

    // geometry stays put unless a geometry command is taken
    geometry_hold_a: assert property (@(posedge core_clk) disable iff (rst) // see R21
        !(state_r == ST_READY && cmd_valid && is_geom)
        |=> $stable(sectors_per_track) && $stable(head_max))
        else $error("geometry changed unasked");

    // geometry runs the same busy and interrupt sequence
    geometry_seq_a: assert property (@(posedge core_clk) disable iff (rst) // see R21
        state_r == ST_READY && cmd_valid && is_geom |=> busy_status_bit ##1 cmd_irq)
        else $error("geometry sequence wrong");

    // erase time code passes through unchanged
    erase_word_a: assert property (@(posedge core_clk) disable iff (rst) // see R1
        word_idx == `WORD_ERASE_TIME |-> word_data == {8'h00, cfg.erase_time})
        else $error("erase word wrong");

    // power level in the low byte only
    apm_word_a: assert property (@(posedge core_clk) disable iff (rst) // see R2
        word_idx == `WORD_APM_LEVEL |-> word_data == {8'h00, cfg.apm_level})
        else $error("apm word wrong");

    // level bit only means something with security enabled
    level_bit_a: assert property (@(posedge core_clk) disable iff (rst) // see R3
        word_idx == `WORD_SEC_STATUS |-> word_data[8] == (cfg.sec_max_level && cfg.sec_enabled))
        else $error("level bit wrong");

    // enhanced erase support flag
    enh_erase_a: assert property (@(posedge core_clk) disable iff (rst) // see R4
        word_idx == `WORD_SEC_STATUS |-> word_data[5] == cfg.enh_erase_sup)
        else $error("enhanced erase bit wrong");

    // frozen, locked, enabled and supported in the low nibble
    sec_flags_a: assert property (@(posedge core_clk) disable iff (rst) // see R6
        word_idx == `WORD_SEC_STATUS
        |-> word_data[3:0] == {cfg.sec_frozen, cfg.sec_locked, cfg.sec_enabled, cfg.sec_supported})
        else $error("security flags wrong");

    // reserved bit low, current passed through
    power_rsv_a: assert property (@(posedge core_clk) disable iff (rst) // see R7
        word_idx == `WORD_POWER_REQ |-> !word_data[14] && word_data[11:0] == cfg.max_current_ma)
        else $error("power word wrong");

    // level 1 command flags
    power_flags_a: assert property (@(posedge core_clk) disable iff (rst) // see R8
        word_idx == `WORD_POWER_REQ
        |-> word_data[13:12] == {cfg.no_level1_commands, cfg.level1_commands_disabled})
        else $error("level1 flags wrong");

    // only the key scheme bit may be set
    key_rsv_a: assert property (@(posedge core_clk) disable iff (rst) // see R10
        word_idx == `WORD_KEY_MGMT |-> word_data[15:1] == 15'h0000)
        else $error("key word reserved set");

    // pio code never reserved, top nibble clear
    timing_rsv_a: assert property (@(posedge core_clk) disable iff (rst) // see R11
        word_idx == `WORD_IDE_TIMING |-> word_data[15:12] == 4'h0 && word_data[2:0] < 3'h3)
        else $error("ide timing word wrong");

    // dma codes never reserved
    dma_code_a: assert property (@(posedge core_clk) disable iff (rst) // see R12
        word_idx == `WORD_IDE_TIMING |-> word_data[5:3] < 3'h3 && word_data[11:9] < 3'h3)
        else $error("dma code reserved");

    // io cycle code never reserved
    io_cycle_a: assert property (@(posedge core_clk) disable iff (rst) // see R13
        word_idx == `WORD_CARD_TIMING |-> word_data[2:0] < 3'h4)
        else $error("io cycle code reserved");

    // memory cycle code never reserved
    mem_cycle_a: assert property (@(posedge core_clk) disable iff (rst) // see R14
        word_idx == `WORD_CARD_TIMING |-> word_data[5:3] < 3'h4)
        else $error("memory cycle code reserved");

    // io udma maximum never reserved
    udma_io_a: assert property (@(posedge core_clk) disable iff (rst) // see R15
        word_idx == `WORD_CARD_TIMING |-> word_data[8:6] != 3'h7)
        else $error("io udma code reserved");

    // memory udma maximum never reserved
    udma_mem_a: assert property (@(posedge core_clk) disable iff (rst) // see R16
        word_idx == `WORD_CARD_TIMING |-> word_data[11:9] != 3'h7)
        else $error("memory udma code reserved");

    // selected udma never reserved
    udma_sel_a: assert property (@(posedge core_clk) disable iff (rst) // see R17
        word_idx == `WORD_CARD_TIMING |-> word_data[14:12] != 3'h7)
        else $error("selected udma reserved");

    // top bit follows the valid flag
    card_valid_a: assert property (@(posedge core_clk) disable iff (rst) // see R18
        word_idx == `WORD_CARD_TIMING |-> word_data[15] == cfg.card_udma_valid)
        else $error("udma valid bit wrong");

    // without the valid flag the udma maximum fields read zero
    udma_valid_a: assert property (@(posedge core_clk) disable iff (rst) // see R18
        word_idx == `WORD_CARD_TIMING && !cfg.card_udma_valid |-> word_data[11:6] == 6'h00)
        else $error("udma fields without valid");

    // any other word reads zero
    unlisted_word_a: assert property (@(posedge core_clk) disable iff (rst) // see R23
        !(word_idx inside {`WORD_ERASE_TIME, `WORD_APM_LEVEL, `WORD_SEC_STATUS,
          `WORD_POWER_REQ, `WORD_KEY_MGMT, `WORD_IDE_TIMING, `WORD_CARD_TIMING})
        |-> word_data == 16'h0000)
        else $error("unlisted word not zero");
endmodule
`default_nettype wire

/* verif/host_model.sv */
// host controller model that offers task-file commands to the card
`default_nettype none
module host_model
(
    input  wire logic                 core_clk,
    output var  logic                 cmd_valid,
    output var  idcmd_pkg::taskfile_s cmd_tf
);
    timeunit 1ns;
    timeprecision 1ns;
    import idcmd_pkg::*;

    initial
    begin
        cmd_valid = 1'b0;
        cmd_tf = '0;
    end

    // one command, offered on a falling edge and held across the taking edge
    task automatic issue(input taskfile_s tf);
        taskfile_s t;
        t = tf;
        if (t.opcode == 8'h91)
            t.drive_head[6] = 1'b0;
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_tf = t;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        // released bus: inverted so a stale command is never mistaken for a live one
        cmd_tf = ~t;
    endtask
endmodule
`default_nettype wire

/* verif/ata_identify_power_cmds_tb_top.sv */
// self-checking bench for identify words and idle/geometry commands
`default_nettype none
module ata_identify_power_cmds_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import idcmd_pkg::*;

    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       cmd_valid;
    taskfile_s  cmd_tf;
    ident_cfg_s cfg = '0;
    logic       sec_count_exhausted = 1'b0;
    logic       host_activity = 1'b0;
    logic [7:0] word_idx = 8'h00;
    logic [15:0] word_data;
    logic       busy, abort, irq, idle_mode, powerdown, sec_expired;
    logic [7:0] sectors_per_track;
    logic [3:0] head_max;
    int         num_errors = 0;
    int         checked = 0;
    int         wait_n = 0;
    logic [7:0] idx_list [9] = '{8'h5A, 8'h5B, 8'h80, 8'hA0, 8'hA2, 8'hA3, 8'hA4, 8'h00, 8'hA1};
    logic [7:0] idle_ops [4] = '{8'h97, 8'hE3, 8'h95, 8'hE1};

    always #50 core_clk = ~core_clk;

    host_model host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_tf(cmd_tf));

    ata_identify_power_cmds #(.TICK_CYC(10)) dut
    (
        .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_tf(cmd_tf),
        .cfg(cfg), .sec_count_exhausted(sec_count_exhausted),
        .host_activity(host_activity), .word_idx(word_idx), .word_data(word_data),
        .busy_status_bit(busy), .cmd_abort(abort), .cmd_irq(irq),
        .idle_mode(idle_mode), .powerdown(powerdown), .sec_expired(sec_expired),
        .sectors_per_track(sectors_per_track), .head_max(head_max)
    );

    task automatic print_verdict();
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // reserved codes read back as zero
    function automatic logic [2:0] cl(input logic [2:0] v, input logic [2:0] m);
        return (v > m) ? 3'h0 : v;
    endfunction

    function automatic logic [15:0] ew(input logic [7:0] i, input ident_cfg_s c, input logic x);
        case (i)
            8'h5A: return {8'h00, c.erase_time};
            8'h5B: return {8'h00, c.apm_level};
            8'h80: return {7'h00, c.sec_max_level & c.sec_enabled, 2'h0, c.enh_erase_sup, x,
                           c.sec_frozen, c.sec_locked, c.sec_enabled, c.sec_supported};
            8'hA0: return {c.power_desc_valid, 1'b0, c.no_level1_commands,
                           c.level1_commands_disabled, c.max_current_ma};
            8'hA2: return {15'h0000, c.key_scheme_sup};
            8'hA3: return {4'h0, cl(c.dma_sel, 3'h2), cl(c.pio_sel, 3'h2),
                           cl(c.dma_max, 3'h2), cl(c.pio_max, 3'h2)};
            8'hA4: return {c.card_udma_valid, cl(c.udma_sel, 3'h6),
                           {3{c.card_udma_valid}} & cl(c.mem_udma_max, 3'h6),
                           {3{c.card_udma_valid}} & cl(c.io_udma_max, 3'h6),
                           cl(c.mem_cycle, 3'h3), cl(c.io_cycle, 3'h3)};
            default: return 16'h0000;
        endcase
    endfunction

    // activity first so idle_mode starts low, then one command and its two-cycle answer
    task automatic cmd(input logic [7:0] op, input logic [7:0] cnt, input logic [7:0] dh,
                       input logic acc, input logic ab, input logic idl);
        @(negedge core_clk);
        host_activity = 1'b1;
        @(negedge core_clk);
        host_activity = 1'b0;
        host.issue({op, cnt, dh});
        chk("busy", busy, acc);
        chk("abort", abort, ab);
        chk("irq_early", irq, ab);
        @(negedge core_clk);
        chk("busy_end", busy, 16'h0000);
        chk("irq", irq, acc);
        chk("idle_mode", idle_mode, idl);
        @(negedge core_clk);
    endtask

    initial
    begin
        #(3000 * 100);
        num_errors++;
        print_verdict();
    end

    initial
    begin
        repeat (20) @(posedge core_clk);
        chk("spt_rst", sectors_per_track, 16'h003F);
        chk("head_rst", head_max, 16'h000F);
        chk("exp_rst", sec_expired, 16'h0000);
        @(negedge core_clk);
        rst = 1'b0;
        // identify words over several field patterns, reserved codes included
        for (int p = 0; p < 5; p++)
        begin
            @(negedge core_clk);
            case (p)
                0: cfg = '1;
                1: cfg = {22{3'h2}};
                2: cfg = {22{3'h5}};
                3: cfg = {22{3'h1}};
                default: cfg = {22{3'h6}};
            endcase
            foreach (idx_list[k])
            begin
                @(negedge core_clk);
                word_idx = idx_list[k];
                #1;
                chk("word", word_data, ew(word_idx, cfg, 1'b0));
            end
        end
        foreach (idle_ops[k])
            cmd(idle_ops[k], 8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
        // count 2 at 10-cycle ticks: powerdown after 20 quiet cycles
        cmd(8'h97, 8'h02, 8'h00, 1'b1, 1'b0, 1'b1);
        repeat (10) @(negedge core_clk);
        chk("pd_early", powerdown, 16'h0000);
        // load plus two 10-cycle ticks: nine falling edges past the early check
        for (wait_n = 0; wait_n < 30 && powerdown !== 1'b1; wait_n++)
            @(negedge core_clk);
        chk("pd", powerdown, 16'h0001);
        chk("pd_time", wait_n[15:0], 16'h0009);
        cmd(8'hE3, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
        repeat (40) @(negedge core_clk);
        chk("pd_off", powerdown, 16'h0000);
        cmd(8'h91, 8'h11, 8'hE5, 1'b1, 1'b0, 1'b0);
        chk("spt", sectors_per_track, 16'h0011);
        chk("heads", head_max, 16'h0005);
        cmd(8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        cmd(8'hF2, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        sec_count_exhausted = 1'b1;
        @(negedge core_clk);
        sec_count_exhausted = 1'b0;
        @(negedge core_clk);
        chk("expired", sec_expired, 16'h0001);
        word_idx = 8'h80;
        #1;
        chk("word128", word_data, ew(8'h80, cfg, 1'b1));
        cmd(8'hF2, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
        cmd(8'hF4, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
        rst = 1'b1;
        @(negedge core_clk);
        rst = 1'b0;
        chk("exp_clear", sec_expired, 16'h0000);
        cmd(8'hF4, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
